//--- hdl/dbs_pkg.sv
package dbs_pkg;
   // ==========================================
   // geometry of the x18 port
   localparam int DBS_LANE_W = 9;
   localparam int DBS_LANES = 2;
   localparam int DBS_DATA_W = DBS_LANE_W * DBS_LANES;
   localparam int DBS_ADDR_W = 8;
   localparam int DBS_WORD_AW = DBS_ADDR_W + 1;
   localparam int DBS_DEPTH = 1 << DBS_WORD_AW;
   localparam logic DBS_BEAT0_LSB = 1'h0;
   localparam logic DBS_BEAT1_LSB = 1'h1;
   localparam logic [1:0] DBS_OCLK_TIED = 2'h3;

   // ==========================================
   // one captured write beat
   typedef struct packed {
      logic [DBS_DATA_W-1:0] data;
      logic [DBS_LANES-1:0] mask_n;
   } dbs_beat_t;

   // sampled pin set: command strobes with address
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic [DBS_ADDR_W-1:0] addr;
   } dbs_cmd_t;
endpackage : dbs_pkg

//--- hdl/dbs_mem.sv
`timescale 1ns/10ps
`default_nettype none
module dbs_mem
   import dbs_pkg::*;
(
   // clock
   input wire logic i_clk,
   // write side
   input wire logic i_we,
   input wire logic [DBS_WORD_AW-1:0] i_waddr,
   input wire logic [DBS_DATA_W-1:0] i_wdata,
   input wire logic [DBS_LANES-1:0] i_wlane,
   // read side, registered data
   input wire logic [DBS_WORD_AW-1:0] i_raddr,
   output logic [DBS_DATA_W-1:0] o_rdata
);
   // ==========================================
   // storage
   logic [DBS_DATA_W-1:0] mem [DBS_DEPTH];

   // lane-enabled write, masked lanes keep old contents
   always_ff @(posedge i_clk) begin
      for (int l = 0; l < DBS_LANES; l++) begin
         if (i_we && i_wlane[l]) begin
            mem[i_waddr][l*DBS_LANE_W +: DBS_LANE_W] <= i_wdata[l*DBS_LANE_W +: DBS_LANE_W];
         end
      end
   end

   // registered read port
   always_ff @(posedge i_clk) begin
      o_rdata <= mem[i_raddr];
   end
endmodule : dbs_mem
`default_nettype wire

//--- hdl/dbs_port.sv
// Behaviour
// RL1: sample address and read strobe each K rise
// RL2: read beats one cycle, then half later
// RL3: read strobe high gives read deselect
// RL4: write strobe on K, address on K-bar
// RL5: first write beat taken with command
// RL6: second beat and address on K-bar
// RL7: write strobe high stores nothing
// RL8: ports never interrupt each other
// RL9: started bursts always finish both beats
// RL10: both strobes high deselect both ports
// RL11: inputs sampled only at clock edges
// RL12: masks sampled with each data beat
// RL13: high mask bit leaves lane unchanged
// RL14: nine-bit lanes masked independently per beat
// RL15: one address covers a two-beat word
// RL16: output registers fired by output clocks
// RL17: output clocks tied high use K
// RL18: echo clocks copy the firing clock
// RL19: true and inverted echo outputs
// RL20: echo clocks never stop
// RL21: read or write may come first
// RL22: x18 has two mask inputs
// RL23: address lsb forced 0 then 1
// RL24: same-cycle read of write address passes through
// RL25: read deselect floats the data outputs
`timescale 1ns/10ps
`default_nettype none
module dbs_port
   import dbs_pkg::*;
(
   // system
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // input clock pair
   input wire logic i_k_clk,
   input wire logic i_k_clk_n,
   // output clock pair
   input wire logic i_c_clk,
   input wire logic i_c_clk_n,
   // command and address
   input wire logic i_read_n,
   input wire logic i_write_n,
   input wire logic [DBS_ADDR_W-1:0] i_sync_addr_bus,
   // write data
   input wire logic [DBS_DATA_W-1:0] i_write_data_in,
   input wire logic [DBS_LANES-1:0] i_byte_mask_n_narrow, // RL22
   // read data
   output logic [DBS_DATA_W-1:0] o_read_data_out,
   output logic o_read_data_oe,
   // echo clocks
   output logic o_echo_clk_out,
   output logic o_echo_clk_out_n
);
   // ==========================================
   // reset release
   logic rst_s1;
   logic rst;
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_s1 <= 1'h0;
         rst <= 1'h0;
      end else begin
         rst_s1 <= 1'h1;
         rst <= rst_s1;
      end
   end

   // ==========================================
   // pin synchronisers, two stages before any use
   localparam int SW = 4 + 2 + DBS_ADDR_W + DBS_DATA_W + DBS_LANES;
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] pin_s1;
   logic [SW-1:0] pin_s2;
   logic [3:0] clk_d;
   assign pin_raw = {i_k_clk, i_k_clk_n, i_c_clk, i_c_clk_n, i_read_n, i_write_n,
                     i_sync_addr_bus, i_write_data_in, i_byte_mask_n_narrow};
   // data pins share the clock delay so edges see aligned values
   always_ff @(posedge i_clk_sys or negedge rst) begin
      if (!rst) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         clk_d <= '0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         clk_d <= pin_s2[SW-1 -: 4];
      end
   end

   logic k_s;
   logic kn_s;
   logic c_s;
   logic cn_s;
   dbs_cmd_t cmd; // RL11
   dbs_beat_t beat; // RL12
   assign {k_s, kn_s, c_s, cn_s} = pin_s2[SW-1 -: 4];
   assign cmd = pin_s2[DBS_DATA_W + DBS_LANES +: 2 + DBS_ADDR_W];
   assign beat = pin_s2[DBS_DATA_W + DBS_LANES - 1:0];

   // edge detect on synchronised clocks only
   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction : rise
   logic k_rise;
   logic kn_rise;
   logic c_rise;
   logic cn_rise;
   assign k_rise = rise(k_s, clk_d[3]);
   assign kn_rise = rise(kn_s, clk_d[2]);
   assign c_rise = rise(c_s, clk_d[1]);
   assign cn_rise = rise(cn_s, clk_d[0]);

   // output clocks tied high select K control
   logic oclk_tied;
   assign oclk_tied = ({c_s, cn_s} == DBS_OCLK_TIED); // RL17
   logic fire_p;
   logic fire_n;
   assign fire_p = oclk_tied ? k_rise : c_rise; // RL16 RL17
   assign fire_n = oclk_tied ? kn_rise : cn_rise;

   // ==========================================
   // write port: command on K, address and beat 1 on K-bar
   typedef enum logic [0:0] {WR_IDLE, WR_BEAT1} dbs_wr_t;
   dbs_wr_t wr_state;
   dbs_beat_t wbeat0;
   logic mem_we;
   logic [DBS_WORD_AW-1:0] mem_waddr;
   logic [DBS_DATA_W-1:0] mem_wdata;
   logic [DBS_LANES-1:0] mem_wlane;
   logic wr_done;
   logic [DBS_DATA_W-1:0] wr_pass0;
   logic [DBS_DATA_W-1:0] wr_pass1;
   logic [DBS_LANES-1:0] wr_pm0;
   logic [DBS_LANES-1:0] wr_pm1;

   // burst sequencer, new commands ignored until beat 1 lands
   always_ff @(posedge i_clk_sys or negedge rst) begin
      if (!rst) begin
         wr_state <= WR_IDLE;
         wbeat0 <= '0;
      end else begin
         case (wr_state)
            WR_IDLE: begin
               if (k_rise && !cmd.wr_n) begin // RL4 RL7 RL21
                  wbeat0 <= beat; // RL5 RL12
                  wr_state <= WR_BEAT1;
               end
            end
            WR_BEAT1: begin
               if (kn_rise) begin // RL9
                  wr_state <= WR_IDLE;
               end
            end
            default: wr_state <= WR_IDLE;
         endcase
      end
   end

   // two memory writes: beat 0 then beat 1, one per system clock
   logic wr_second;
   logic [DBS_ADDR_W-1:0] wr_hold_a;
   dbs_beat_t wbeat1;
   always_ff @(posedge i_clk_sys or negedge rst) begin
      if (!rst) begin
         mem_we <= 1'h0;
         mem_waddr <= '0;
         mem_wdata <= '0;
         mem_wlane <= '0;
         wr_second <= 1'h0;
         wr_hold_a <= '0;
         wbeat1 <= '0;
      end else begin
         mem_we <= 1'h0;
         wr_second <= 1'h0;
         if (wr_state == WR_BEAT1 && kn_rise) begin
            mem_we <= 1'h1; // RL15
            mem_waddr <= {cmd.addr, DBS_BEAT0_LSB}; // RL6 RL23
            mem_wdata <= wbeat0.data;
            mem_wlane <= ~wbeat0.mask_n; // RL13 RL14
            wr_second <= 1'h1;
            wr_hold_a <= cmd.addr;
            wbeat1 <= beat; // RL6 RL12
         end else if (wr_second) begin
            mem_we <= 1'h1;
            mem_waddr <= {wr_hold_a, DBS_BEAT1_LSB}; // RL23
            mem_wdata <= wbeat1.data;
            mem_wlane <= ~wbeat1.mask_n; // RL13 RL14
         end
      end
   end

   // ==========================================
   // read port: fetch both words while the cycle runs
   logic [DBS_WORD_AW-1:0] rd_addr;
   logic [DBS_DATA_W-1:0] mem_rdata;
   logic rd_pend;
   logic [DBS_ADDR_W-1:0] rd_base;
   logic [2:0] rd_step;
   logic [DBS_DATA_W-1:0] rd_w0;
   logic [DBS_DATA_W-1:0] rd_w1;
   dbs_mem u_mem (
      .i_clk(i_clk_sys),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(mem_wdata),
      .i_wlane(mem_wlane),
      .i_raddr(rd_addr),
      .o_rdata(mem_rdata)
   );

   // pass-through flag taken when the write address lands on K-bar
   // the write address only arrives after the read fetch has run, so the
   // merge is done at launch; the flag stands until the next K-bar
   always_ff @(posedge i_clk_sys or negedge rst) begin
      if (!rst) begin
         wr_done <= 1'h0;
         wr_pass0 <= '0;
         wr_pass1 <= '0;
         wr_pm0 <= '0;
         wr_pm1 <= '0;
      end else if (kn_rise) begin
         wr_done <= (wr_state == WR_BEAT1) && rd_pend && (cmd.addr == rd_base); // RL24
         if (wr_state == WR_BEAT1) begin
            wr_pass0 <= wbeat0.data;
            wr_pass1 <= beat.data;
            wr_pm0 <= ~wbeat0.mask_n;
            wr_pm1 <= ~beat.mask_n;
         end
      end
   end

   // read command latched on K; runs alongside any write
   always_ff @(posedge i_clk_sys or negedge rst) begin
      if (!rst) begin
         rd_pend <= 1'h0;
         rd_base <= '0;
         rd_step <= '0;
      end else begin
         rd_step <= {rd_step[1:0], 1'h0};
         if (k_rise) begin // RL1 RL8 RL10
            rd_pend <= !cmd.rd_n; // RL2 RL3
            if (!cmd.rd_n) begin
               rd_base <= cmd.addr;
               rd_step <= 3'h1;
            end
         end
      end
   end
   assign rd_addr = {rd_base, rd_step[1] ? DBS_BEAT1_LSB : DBS_BEAT0_LSB}; // RL23

   // merge a matching write word over stored data, lane by lane
   function automatic logic [DBS_DATA_W-1:0] merge(input logic [DBS_DATA_W-1:0] old,
                                                 input logic [DBS_DATA_W-1:0] nw,
                                                 input logic [DBS_LANES-1:0] en);
      logic [DBS_DATA_W-1:0] r;
      r = old;
      for (int l = 0; l < DBS_LANES; l++) begin
         if (en[l]) begin
            r[l*DBS_LANE_W +: DBS_LANE_W] = nw[l*DBS_LANE_W +: DBS_LANE_W];
         end
      end
      merge = r;
   endfunction : merge

   logic hit;
   assign hit = wr_done; // RL24
   // fetched words, stored contents only
   always_ff @(posedge i_clk_sys or negedge rst) begin
      if (!rst) begin
         rd_w0 <= '0;
         rd_w1 <= '0;
      end else begin
         if (rd_step[1]) begin
            rd_w0 <= mem_rdata;
         end
         if (rd_step[2]) begin
            rd_w1 <= mem_rdata;
         end
      end
   end

   // ==========================================
   // output registers: beat 0 on next fire rise, beat 1 on fire-bar
   // a delayed output pair rises after the K edge that shifts the arm,
   // so it reads the arm one stage deeper and launches the same command as K firing does
   logic [1:0] out_arm;
   logic out_sel;
   logic out_beat1;
   logic [DBS_DATA_W-1:0] hold_w1;
   assign out_sel = oclk_tied ? out_arm[0] : out_arm[1]; // RL16 RL17
   always_ff @(posedge i_clk_sys or negedge rst) begin
      if (!rst) begin
         o_read_data_out <= '0;
         o_read_data_oe <= 1'h0;
         out_arm <= '0;
         out_beat1 <= 1'h0;
         hold_w1 <= '0;
      end else begin
         if (k_rise) begin
            out_arm <= {out_arm[0], !cmd.rd_n};
         end
         if (fire_p) begin
            out_beat1 <= out_sel; // RL9
            o_read_data_oe <= out_sel; // RL25
            if (out_sel) begin
               o_read_data_out <= hit ? merge(rd_w0, wr_pass0, wr_pm0) : rd_w0; // RL2 RL24
               // beat 1 frozen here: a following read refills the fetch words
               hold_w1 <= hit ? merge(rd_w1, wr_pass1, wr_pm1) : rd_w1; // RL24
            end
         end else if (fire_n && out_beat1) begin
            o_read_data_out <= hold_w1; // RL2 RL9
            out_beat1 <= 1'h0;
         end
      end
   end

   // ==========================================
   // echo clocks follow the firing pair, always running
   always_ff @(posedge i_clk_sys or negedge rst) begin
      if (!rst) begin
         o_echo_clk_out <= 1'h0;
         o_echo_clk_out_n <= 1'h1;
      end else begin
         o_echo_clk_out <= oclk_tied ? k_s : c_s; // RL18 RL19 RL20
         o_echo_clk_out_n <= oclk_tied ? kn_s : cn_s; // RL18 RL19
      end
   end
endmodule : dbs_port
`default_nettype wire

//--- verification/dbs_port_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// echo clock and read port timing
module dbs_port_chk
   import dbs_pkg::*;
(
   // system and clock pairs
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_k_clk,
   input wire logic i_k_clk_n,
   input wire logic i_c_clk,
   input wire logic i_c_clk_n,
   // commands
   input wire logic i_read_n,
   input wire logic i_write_n,
   // outputs
   input wire logic [DBS_DATA_W-1:0] o_read_data_out,
   input wire logic o_read_data_oe,
   input wire logic o_echo_clk_out,
   input wire logic o_echo_clk_out_n
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);
   // outputs follow the pins only after reset and pin synchronisers drain
   logic [3:0] settle;
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         settle <= '0;
      end else if (settle != 4'hF) begin
         settle <= settle + 4'h1;
      end
   end
   // echo pair follows the firing pair, never stops
   a_echo_pair: assert property (settle == 4'hF |-> o_echo_clk_out_n != o_echo_clk_out)
      else $error("echo outputs not complementary");
   a_echo_k_rise: assert property ($rose(i_k_clk) |-> ##[1:10] $rose(o_echo_clk_out))
      else $error("echo clock missed a K rise");
   a_echo_kbar: assert property ($rose(i_k_clk_n) |-> ##[1:10] $rose(o_echo_clk_out_n))
      else $error("inverted echo missed a K-bar rise");
   // with the output pair running, K alone must not fire the echo
   a_echo_waits_c: assert property ($rose(i_k_clk) && !i_c_clk |-> !o_echo_clk_out [*3])
      else $error("echo fired by K while output clocks run");
   a_echo_k_tied: assert property (i_c_clk && i_c_clk_n && $rose(i_k_clk) |-> ##[1:6] o_echo_clk_out)
      else $error("echo not fired by K with output clocks tied");
   a_data_with_echo: assert property ($changed(o_read_data_out) |-> ##[0:2] $changed(o_echo_clk_out))
      else $error("read data moved without echo");
   // read port answer one K period later, deselect floats
   a_read_drive: assert property ($rose(i_k_clk) && !i_read_n |-> ##[14:22] o_read_data_oe)
      else $error("read data not driven");
   a_desel_float: assert property ($rose(i_k_clk) && i_read_n |-> ##[14:22] !o_read_data_oe)
      else $error("outputs driven in deselect");
   c_read_write: cover property ($rose(i_k_clk) && !i_read_n && !i_write_n);
   c_desel: cover property ($rose(i_k_clk) && i_read_n && i_write_n);
   c_tied: cover property (i_c_clk && i_c_clk_n && $rose(o_echo_clk_out));
endmodule : dbs_port_chk
bind dbs_port dbs_port_chk chk_u (
   .i_clk_sys, .i_reset_n, .i_k_clk, .i_k_clk_n, .i_c_clk, .i_c_clk_n, .i_read_n,
   .i_write_n, .o_read_data_out, .o_read_data_oe, .o_echo_clk_out, .o_echo_clk_out_n
);
`default_nettype wire

//--- verification/dbs_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// memory controller: clock pairs, commands, read sampling
module dbs_ctrl_model
   import dbs_pkg::*;
(
   // clock pairs
   output logic o_k,
   output logic o_k_n,
   output logic o_c,
   output logic o_c_n,
   // commands and write beats
   output dbs_cmd_t o_cmd,
   output dbs_beat_t o_beat,
   // read side
   input wire logic [DBS_DATA_W-1:0] i_q,
   input wire logic i_oe
);
   logic c_tied;
   logic [DBS_DATA_W-1:0] q0, q1;
   logic oe0, oe1;
   // idle levels; output pair starts running
   initial begin
      c_tied = 1'h0;
      o_k = 1'h0;
      o_k_n = 1'h1;
      o_c = 1'h0;
      o_c_n = 1'h1;
      o_cmd = '{1'h1, 1'h1, 8'h00};
      o_beat = '0;
   end
   // one K period; 30 ns hold keeps the 3-cycle sampler happy
   task automatic cycle(input logic rd_n, input logic wr_n, input logic [DBS_ADDR_W-1:0] ra,
         input logic [DBS_ADDR_W-1:0] wa, input dbs_beat_t b0, input dbs_beat_t b1);
      o_cmd = '{rd_n, wr_n, ra};
      o_beat = b0;
      #30 o_k = 1'h1;
      o_k_n = 1'h0;
      #15 o_c = 1'h1;
      o_c_n = c_tied;
      q1 = i_q;
      oe1 = i_oe;
      #16 o_cmd.addr = wa;
      o_beat = b1;
      #30 o_k = 1'h0;
      o_k_n = 1'h1;
      #15 o_c = c_tied;
      o_c_n = 1'h1;
      q0 = i_q;
      oe0 = i_oe;
      #19;
   endtask : cycle
endmodule : dbs_ctrl_model
`default_nettype wire

//--- verification/dbs_port_test.sv
`timescale 1ns/10ps
`default_nettype none
module dbs_port_test;
   import dbs_pkg::*;
   logic clk_sys, reset_n, k, k_n, c, c_n, oe, echo, echo_n;
   dbs_cmd_t cmd;
   dbs_beat_t beat;
   logic [DBS_DATA_W-1:0] q, pe0;
   logic [DBS_DATA_W-1:0] pe1 [2];
   logic [DBS_DATA_W-1:0] shadow [DBS_DEPTH];
   logic [1:0] pend;
   int failures, samples_checked;
   // ====================
   // design and controller
   dbs_port dut_u (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_k_clk(k), .i_k_clk_n(k_n),
      .i_c_clk(c), .i_c_clk_n(c_n), .i_read_n(cmd.rd_n), .i_write_n(cmd.wr_n),
      .i_sync_addr_bus(cmd.addr), .i_write_data_in(beat.data),
      .i_byte_mask_n_narrow(beat.mask_n), .o_read_data_out(q), .o_read_data_oe(oe),
      .o_echo_clk_out(echo), .o_echo_clk_out_n(echo_n));
   dbs_ctrl_model ctl_u (.o_k(k), .o_k_n(k_n), .o_c(c), .o_c_n(c_n), .o_cmd(cmd),
      .o_beat(beat), .i_q(q), .i_oe(oe));
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   // hang guard; the sequence needs about 4 us
   initial begin
      #100000;
      failures++;
      end_of_test();
   end
   task automatic end_of_test;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [DBS_DATA_W-1:0] got, input logic [DBS_DATA_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   // masked lanes keep their old contents
   function automatic logic [DBS_DATA_W-1:0] merge(input logic [DBS_DATA_W-1:0] old,
         input dbs_beat_t b);
      merge = old;
      for (int l = 0; l < DBS_LANES; l++)
         if (!b.mask_n[l]) merge[l*DBS_LANE_W +: DBS_LANE_W] = b.data[l*DBS_LANE_W +: DBS_LANE_W];
   endfunction : merge
   // one K period; beat0 is judged one period later, beat1 two
   task automatic op(input logic rd_n, input logic wr_n, input logic [DBS_ADDR_W-1:0] ra,
         input logic [DBS_ADDR_W-1:0] wa, input dbs_beat_t b0, input dbs_beat_t b1);
      if (!wr_n) begin
         shadow[{wa, DBS_BEAT0_LSB}] = merge(shadow[{wa, DBS_BEAT0_LSB}], b0);
         shadow[{wa, DBS_BEAT1_LSB}] = merge(shadow[{wa, DBS_BEAT1_LSB}], b1);
      end
      ctl_u.cycle(rd_n, wr_n, ra, wa, b0, b1);
      check({17'h0, ctl_u.oe0}, {17'h0, pend[0]});
      check({17'h0, ctl_u.oe1}, {17'h0, pend[1]});
      if (pend[0]) check(ctl_u.q0, pe0);
      if (pend[1]) check(ctl_u.q1, pe1[1]);
      pend = {pend[0], ~rd_n};
      pe1[1] = pe1[0];
      pe0 = shadow[{ra, DBS_BEAT0_LSB}];
      pe1[0] = shadow[{ra, DBS_BEAT1_LSB}];
   endtask : op
   task automatic flush;
      repeat (2) op(1'h1, 1'h1, 8'h00, 8'h00, '0, '0);
   endtask : flush
   task automatic t_basic(input logic [DBS_ADDR_W-1:0] a);
      op(1'h1, 1'h0, 8'h00, a, '{18'h2A5B1, 2'h0}, '{18'h1C3D4, 2'h0});
      op(1'h0, 1'h1, a, 8'h00, '0, '0);
      flush();
   endtask : t_basic
   // every mask pair, read in the same period as the masked write
   task automatic t_masks;
      for (int m = 0; m < 4; m++) begin
         op(m == 0, 1'h0, 8'h2F + m[7:0], 8'h30 + m[7:0], '{18'h3FFFF, 2'h0}, '{18'h3FFFF, 2'h0});
         op(1'h0, 1'h0, 8'h30 + m[7:0], 8'h30 + m[7:0], '{18'h00000, m[1:0]}, '{18'h15555, ~m[1:0]});
      end
      flush();
   endtask : t_masks
   task automatic t_desel;
      op(1'h1, 1'h1, 8'h00, 8'h31, '{18'h0F0F0, 2'h0}, '{18'h0F0F0, 2'h0});
      op(1'h0, 1'h1, 8'h31, 8'h00, '0, '0);
      flush();
   endtask : t_desel
   task automatic t_alt;
      op(1'h0, 1'h1, 8'h30, 8'h00, '0, '0);
      op(1'h1, 1'h0, 8'h00, 8'h60, '{18'h2468A, 2'h0}, '{18'h13579, 2'h0});
      op(1'h0, 1'h0, 8'h60, 8'h30, '{18'h11111, 2'h2}, '{18'h22222, 2'h1});
      op(1'h0, 1'h1, 8'h30, 8'h00, '0, '0);
      flush();
   endtask : t_alt
   initial begin
      failures = 0;
      samples_checked = 0;
      pend = 2'h0;
      reset_n = 1'h0;
      repeat (8) @(posedge clk_sys);
      #2 reset_n = 1'h1;
      repeat (4) @(posedge clk_sys);
      #2;
      flush();
      t_basic(8'h12);
      t_masks();
      t_desel();
      t_alt();
      ctl_u.c_tied = 1'h1;
      flush();
      t_basic(8'hA7);
      end_of_test();
   end
endmodule : dbs_port_test
`default_nettype wire
